// *** hw/isam_top.sv ***
// I2C slave address recognition with general call and address mask
//
// Contract
// [RULE_01] With general call enabled, acknowledge address 0x00 regardless of own address.
// [RULE_02] After all-zero address with write bit, raise the receive event.
// [RULE_03] In 10-bit mode general call never sets the update-address flag.
// [RULE_04] In 10-bit mode, byte after general call is data, as in 7-bit.
// [RULE_05] With address hold on, stretch SCL after 8th fall of general call.
// [RULE_06] Software writes acknowledge value then releases the stretched clock.
// [RULE_07] Mask bit zero makes matching received address bit a don't-care.
// [RULE_08] Address mask resets to all ones on every reset.
// [RULE_09] Mask applies in slave mode to shift register during address compare.
// [RULE_10] In 7-bit mode mask covers received bits seven down to one.
// [RULE_11] In 10-bit mode mask covers low byte only, not high byte.
// [RULE_12] Match when masked received bits equal masked own-address bits.
`timescale 1ns/1ps
module isam_top (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // I2C pins; output enable low while driving low
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_N,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  // Configuration
  input  wire logic        SLAVE_MODE,
  input  wire logic        TEN_BIT_MODE,
  input  wire logic        GENERAL_CALL_ENABLE,
  input  wire logic        ADDRESS_HOLD_ENABLE,
  input  wire logic [9:0]  OWN_ADDRESS_REGISTER,
  // Mask write port
  input  wire logic        MASK_WRITE,
  input  wire logic [7:0]  MASK_WDATA,
  output logic [7:0]       ADDRESS_MASK_REGISTER,
  // Software acknowledge and release
  input  wire logic        ACKNOWLEDGE_DATA_VALUE,
  input  wire logic        CLOCK_RELEASE,
  input  wire logic        UPDATE_ADDRESS_CLEAR,
  // Receive side
  output logic [7:0]       RECEIVE_BUFFER,
  output logic             RECEIVE_EVENT,
  output isam_pkg::isam_stat_s STATUS
);

  // ==========================================================
  // Pin sampling
  isam_pkg::isam_bus_s bus;

  isam_sync u_sync (
    .clk    (CORE_CLK),
    .rst    (RST),
    .scl_in (SCL_IN),
    .sda_in (SDA_IN),
    .bus    (bus)
  );

  // ==========================================================
  // State
  isam_pkg::isam_phase_e phase;
  isam_pkg::isam_phase_e next_phase;
  logic [7:0] receive_shift_register;
  logic [3:0] bit_cnt;
  logic [7:0] mask;
  logic       ack_drive;
  logic       hold;
  logic       gen_call;
  logic       matched;
  logic       ua_flag;

  // Masked compare of two bytes
  function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] m);
    masked_eq = ((a & m) == (b & m)); // RULE_07 RULE_12
  endfunction

  // ==========================================================
  // Address decode
  wire        byte_done   = bus.scl_fall & (bit_cnt == isam_pkg::BIT_EIGHT);
  wire        ack_done    = bus.scl_fall & (bit_cnt == isam_pkg::BIT_NINE);
  wire [7:0]  rx          = receive_shift_register;
  wire [7:0]  mask7       = {mask[7:1], 1'b1}; // RULE_10
  wire [7:0]  own7        = {OWN_ADDRESS_REGISTER[6:0], 1'b0};
  wire        is_gc       = GENERAL_CALL_ENABLE &
                            (rx == isam_pkg::GEN_CALL_BYTE); // RULE_01 RULE_02
  wire        m7          = SLAVE_MODE &
                            masked_eq({rx[7:1], 1'b0}, own7, mask7); // RULE_09 RULE_10
  // High byte of 10-bit address compared without mask
  wire        hi10        = SLAVE_MODE &
                            (rx[7:3] == isam_pkg::TEN_BIT_HEAD) &
                            (rx[2:1] == OWN_ADDRESS_REGISTER[9:8]); // RULE_11
  wire        lo10        = SLAVE_MODE &
                            masked_eq(rx, OWN_ADDRESS_REGISTER[7:0], mask); // RULE_11
  wire        addr_hit    = is_gc | (TEN_BIT_MODE ? hi10 : m7);
  wire        low_hit     = lo10;

  // ==========================================================
  // Phase sequencing
  always_comb begin
    next_phase = phase;
    case (phase)
      isam_pkg::PH_IDLE:     next_phase = isam_pkg::PH_IDLE;
      isam_pkg::PH_ADDR:
        if (byte_done) begin
          if (is_gc)                         next_phase = isam_pkg::PH_DATA; // RULE_04
          else if (TEN_BIT_MODE & hi10)      next_phase = isam_pkg::PH_ADDR_LOW;
          else if (m7)                       next_phase = isam_pkg::PH_DATA;
          else                               next_phase = isam_pkg::PH_IGNORE;
        end
      isam_pkg::PH_ADDR_LOW:
        if (byte_done) begin
          next_phase = low_hit ? isam_pkg::PH_DATA : isam_pkg::PH_IGNORE;
        end
      isam_pkg::PH_DATA:     next_phase = isam_pkg::PH_DATA;
      isam_pkg::PH_IGNORE:   next_phase = isam_pkg::PH_IGNORE;
      default:               next_phase = isam_pkg::PH_IDLE;
    endcase
    if (bus.start) next_phase = isam_pkg::PH_ADDR;
    if (bus.stop)  next_phase = isam_pkg::PH_IDLE;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) phase <= isam_pkg::PH_IDLE;
    else     phase <= next_phase;
  end

  // ==========================================================
  // Shift register and bit counter
  // Counts SCL rises, so the fall that follows a start is never taken as a bit
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      receive_shift_register <= 8'h00;
      bit_cnt                <= 4'h0;
    end else if (bus.start | bus.stop) begin
      bit_cnt <= 4'h0;
    end else begin
      if (bus.scl_rise & (bit_cnt < isam_pkg::BIT_EIGHT))
        receive_shift_register <= {receive_shift_register[6:0], bus.sda};
      if (ack_done)
        bit_cnt <= 4'h0;
      else if (bus.scl_rise)
        bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // ==========================================================
  // Mask register
  always_ff @(posedge CORE_CLK) begin
    if (RST)             mask <= isam_pkg::MASK_RESET; // RULE_08
    else if (MASK_WRITE) mask <= MASK_WDATA;
  end

  // ==========================================================
  // Hold, acknowledge and events
  wire active_byte = (phase == isam_pkg::PH_ADDR) | (phase == isam_pkg::PH_ADDR_LOW) |
                     (phase == isam_pkg::PH_DATA);
  wire byte_ok     = (phase == isam_pkg::PH_ADDR)     ? addr_hit :
                     (phase == isam_pkg::PH_ADDR_LOW) ? low_hit  :
                     (phase == isam_pkg::PH_DATA);
  wire addr_phase  = (phase == isam_pkg::PH_ADDR) | (phase == isam_pkg::PH_ADDR_LOW);
  wire ua_set      = byte_done & TEN_BIT_MODE & (phase == isam_pkg::PH_ADDR) &
                     hi10 & ~is_gc; // RULE_03
  wire ev          = byte_done & active_byte & byte_ok;

  // Receive event and buffer, one cycle after an accepted byte
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RECEIVE_BUFFER <= 8'h00;
      RECEIVE_EVENT  <= 1'b0;
    end else begin
      RECEIVE_EVENT <= ev; // RULE_02
      if (ev)
        RECEIVE_BUFFER <= rx;
    end
  end

  // Clock stretch after an accepted address byte; the set wins over a release
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      hold <= 1'b0;
    else if (ev & addr_phase & ADDRESS_HOLD_ENABLE)
      hold <= 1'b1; // RULE_05
    else if (CLOCK_RELEASE | bus.stop)
      hold <= 1'b0; // RULE_06
  end

  // Acknowledge drive, deferred to the release while the clock is stretched
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      ack_drive <= 1'b0;
    else if (ev)
      ack_drive <= ~(addr_phase & ADDRESS_HOLD_ENABLE);
    else if (hold & CLOCK_RELEASE)
      ack_drive <= ~ACKNOWLEDGE_DATA_VALUE; // RULE_06
    else if (ack_done | bus.stop)
      ack_drive <= 1'b0;
  end

  // Status flags: general call cleared by a start, match by a start or stop, update flag by software
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      gen_call <= 1'b0;
      matched  <= 1'b0;
      ua_flag  <= 1'b0;
    end else begin
      if (bus.start)
        gen_call <= 1'b0;
      else if (ev & (phase == isam_pkg::PH_ADDR) & is_gc)
        gen_call <= 1'b1; // RULE_01
      if (bus.start | bus.stop)
        matched <= 1'b0;
      else if (ev & addr_phase)
        matched <= 1'b1; // RULE_12
      if (ua_set)
        ua_flag <= 1'b1; // RULE_03
      else if (UPDATE_ADDRESS_CLEAR)
        ua_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Pin drive
  assign SCL_OUT  = 1'b0;
  assign SCL_OE_N = ~hold;
  assign SDA_OUT  = 1'b0;
  assign SDA_OE_N = ~ack_drive;
  assign ADDRESS_MASK_REGISTER = mask;
  assign STATUS.gen_call            = gen_call;
  assign STATUS.addr_match          = matched;
  assign STATUS.update_address_flag = ua_flag;
  assign STATUS.hold                = hold;

  // ==========================================================
  // Checks
  // General call address byte completing in the address phase
  sequence s_gc_byte;
    byte_done & (phase == isam_pkg::PH_ADDR) & is_gc;
  endsequence

  // Software release of a stretched clock
  sequence s_release;
    hold & CLOCK_RELEASE;
  endsequence

  // 7-bit address byte completing in slave mode
  sequence s_addr7_byte;
    byte_done & (phase == isam_pkg::PH_ADDR) & SLAVE_MODE & ~TEN_BIT_MODE;
  endsequence

  // General call acknowledged at once when not stretching
  a_gc_ack_drive: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_01
    s_gc_byte ##0 ~ADDRESS_HOLD_ENABLE |=> ack_drive & ~SDA_OE_N)
    else $error("general call not acknowledged");
  // General call raises the receive event with an all-zero buffer
  a_gc_event: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_02
    s_gc_byte |=> RECEIVE_EVENT & (RECEIVE_BUFFER == isam_pkg::GEN_CALL_BYTE))
    else $error("general call event missing");
  // General call leaves the update flag alone
  a_gc_no_ua: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_03
    s_gc_byte ##0 ~ua_flag |=> ~ua_flag)
    else $error("update flag set by general call");
  // Matching 10-bit high byte sets the update flag
  a_ua_high_byte: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_03
    byte_done & (phase == isam_pkg::PH_ADDR) & SLAVE_MODE & TEN_BIT_MODE &
    (rx[7:3] == isam_pkg::TEN_BIT_HEAD) & (rx[2:1] == OWN_ADDRESS_REGISTER[9:8])
    |=> ua_flag)
    else $error("update flag not set by high byte");
  // Byte after a general call is data
  a_gc_to_data: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_04
    s_gc_byte ##0 (~bus.start & ~bus.stop) |=> phase == isam_pkg::PH_DATA)
    else $error("general call not followed by data");
  // Address hold stretches SCL after a general call
  a_gc_hold: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_05
    s_gc_byte ##0 ADDRESS_HOLD_ENABLE |=> ~SCL_OE_N)
    else $error("clock not stretched after general call");
  // Release frees SCL and applies the software acknowledge value
  a_hold_release: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_06
    s_release |=> SCL_OE_N & (SDA_OE_N == $past(ACKNOWLEDGE_DATA_VALUE)))
    else $error("stretch release wrong");
  // Mask reset value after every reset
  a_mask_reset: assert property (@(posedge CORE_CLK) // RULE_08
    RST |=> ADDRESS_MASK_REGISTER == isam_pkg::MASK_RESET)
    else $error("mask reset value wrong");
  // Mask write lands in the register
  a_mask_write: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_07
    MASK_WRITE |=> ADDRESS_MASK_REGISTER == $past(MASK_WDATA))
    else $error("mask write lost");
  // Bits cleared in the mask never cause a miss
  a_mask_dontcare: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_07
    s_addr7_byte ##0 ((({rx[7:1], 1'b0} ^ {OWN_ADDRESS_REGISTER[6:0], 1'b0}) &
                       {mask[7:1], 1'b0}) == 8'h00) |=> RECEIVE_EVENT)
    else $error("masked address missed");
  // A miss in address bits seven to one under the mask refuses the byte
  a_low_bit_free: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_10
    s_addr7_byte ##0 ~(GENERAL_CALL_ENABLE & (rx == isam_pkg::GEN_CALL_BYTE)) ##0
    ((({rx[7:1], 1'b0} ^ {OWN_ADDRESS_REGISTER[6:0], 1'b0}) & {mask[7:1], 1'b0}) != 8'h00)
    |=> ~RECEIVE_EVENT)
    else $error("7-bit match ignores mask bits");
  // Own-address compare only in slave mode; general call is matched in any mode
  a_slave_only: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_09
    byte_done & (phase == isam_pkg::PH_ADDR) & ~SLAVE_MODE &
    (rx != isam_pkg::GEN_CALL_BYTE) |=> ~RECEIVE_EVENT & SDA_OE_N)
    else $error("address matched outside slave mode");
  // High byte of a 10-bit address is compared without the mask
  a_hi_unmasked: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_11
    byte_done & (phase == isam_pkg::PH_ADDR) & TEN_BIT_MODE &
    (rx[7:3] == isam_pkg::TEN_BIT_HEAD) & (rx[2:1] != OWN_ADDRESS_REGISTER[9:8])
    |=> ~RECEIVE_EVENT)
    else $error("high byte masked");
  // Low byte of a 10-bit address is compared through the mask
  a_low_masked: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_11
    byte_done & (phase == isam_pkg::PH_ADDR_LOW) & SLAVE_MODE &
    (((rx ^ OWN_ADDRESS_REGISTER[7:0]) & mask) == 8'h00) |=> RECEIVE_EVENT)
    else $error("masked low byte missed");

endmodule

// *** hw/isam_pkg.sv ***
// Package for the I2C slave address match block
package isam_pkg;

  // Reserved general call address byte
  localparam logic [7:0] GEN_CALL_BYTE  = 8'h00;
  // Mask reset value, all bits compared
  localparam logic [7:0] MASK_RESET     = 8'hFF;
  // Own address reset value
  localparam logic [9:0] OWN_ADDR_RESET = 10'h000;
  // Number of bits in one byte on the wire
  localparam int         BYTE_BITS      = 8;
  // Bit counter value once the eighth bit has been clocked in
  localparam logic [3:0] BIT_EIGHT      = 4'h8;
  // Bit counter value once the acknowledge bit has been clocked
  localparam logic [3:0] BIT_NINE       = 4'h9;
  // Top five bits of a 10-bit high address byte
  localparam logic [4:0] TEN_BIT_HEAD   = 5'h1E;

  // Receive phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_ADDR_LOW,
    PH_DATA,
    PH_IGNORE
  } isam_phase_e;

  // Sampled bus levels and edge events
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } isam_bus_s;

  // Status seen by software
  typedef struct packed {
    logic gen_call;
    logic addr_match;
    logic update_address_flag;
    logic hold;
  } isam_stat_s;

endpackage

// *** hw/isam_sync.sv ***
// Two-stage synchroniser with edge detection for SCL and SDA
`timescale 1ns/1ps
module isam_sync (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Raw pins
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  // Decoded bus events
  output isam_pkg::isam_bus_s   bus
);

  logic [1:0] scl_ff;
  logic [1:0] sda_ff;
  logic       scl_q;
  logic       sda_q;

  // Two flip-flops per pin, then a third stage for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_ff <= 2'b11;
      sda_ff <= 2'b11;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      scl_ff <= {scl_ff[0], scl_in};
      sda_ff <= {sda_ff[0], sda_in};
      scl_q  <= scl_ff[1];
      sda_q  <= sda_ff[1];
    end
  end

  // Edge and condition decode from settled stages only
  assign bus.scl_rise = scl_ff[1] & ~scl_q;
  assign bus.scl_fall = ~scl_ff[1] & scl_q;
  assign bus.start    = scl_ff[1] & scl_q & sda_q & ~sda_ff[1];
  assign bus.stop     = scl_ff[1] & scl_q & ~sda_q & sda_ff[1];
  assign bus.sda      = sda_ff[1];

endmodule

// *** dv/isam_master.sv ***
// I2C bus master model for the address match bench
`timescale 1ns/1ps
module isam_master (
  // Pacing clock
  input  wire logic clk,
  // Resolved bus wires
  input  wire logic scl_w,
  input  wire logic sda_w,
  // Master drives, 1 releases the line
  output logic      scl_d,
  output logic      sda_d,
  // Set when the slave holds SCL beyond the limit
  output logic      stuck
);
  int unsigned ph;

  // Idle bus, both lines released
  initial begin
    scl_d = 1'b1;
    sda_d = 1'b1;
    stuck = 1'b0;
    ph    = 0;
  end

  // Wait a number of falling clock edges
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Release SCL, honour stretching, alternate 12/13 cycle bits for 125 ns
  task automatic scl_high();
    int k;
    scl_d = 1'b1;
    k = 0;
    while (scl_w !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000) stuck = 1'b1;
    ph++;
    wait_n(6 + (ph & 1));
  endtask

  // Start or repeated start
  task automatic start_c();
    sda_d = 1'b1;
    wait_n(3);
    scl_high();
    sda_d = 1'b0;
    wait_n(6);
    scl_d = 1'b0;
    wait_n(3);
  endtask

  // Stop condition, bus left released
  task automatic stop_c();
    sda_d = 1'b0;
    wait_n(3);
    scl_high();
    sda_d = 1'b1;
    wait_n(6);
  endtask

  // One bit, SDA sampled at the end of the high phase
  task automatic put_bit(input logic b, output logic s);
    sda_d = b;
    wait_n(3);
    scl_high();
    s = sda_w;
    scl_d = 1'b0;
    wait_n(3);
  endtask

  // Byte MSB first, then the acknowledge bit with SDA released
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule

// *** dv/isam_top_bench.sv ***
// Self-checking bench for the I2C slave address match block
`timescale 1ns/1ps
module isam_top_bench;
  logic                 clk, rst, scl_d, sda_d, m_stuck, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic                 slave_mode, ten_bit, gce, address_hold_enable, mask_write, ack_val, clk_rel, ua_clr;
  logic [9:0]           own;
  logic [7:0]           mask_wdata, mask_reg, rx_buf;
  logic                 rx_ev;
  isam_pkg::isam_stat_s status;
  int                   err_count, n_checks, ev_cnt;
  wire                  scl_w, sda_w;

  // Open-drain wires with pull-ups
  assign scl_w = scl_d & (scl_oe_n | scl_out);
  assign sda_w = sda_d & (sda_oe_n | sda_out);

  isam_top isam_top_i (.CORE_CLK(clk), .RST(rst), .SCL_IN(scl_w), .SCL_OUT(scl_out),
    .SCL_OE_N(scl_oe_n), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
    .SLAVE_MODE(slave_mode), .TEN_BIT_MODE(ten_bit), .GENERAL_CALL_ENABLE(gce),
    .ADDRESS_HOLD_ENABLE(address_hold_enable), .OWN_ADDRESS_REGISTER(own), .MASK_WRITE(mask_write),
    .MASK_WDATA(mask_wdata), .ADDRESS_MASK_REGISTER(mask_reg),
    .ACKNOWLEDGE_DATA_VALUE(ack_val), .CLOCK_RELEASE(clk_rel),
    .UPDATE_ADDRESS_CLEAR(ua_clr), .RECEIVE_BUFFER(rx_buf), .RECEIVE_EVENT(rx_ev),
    .STATUS(status));
  isam_master isam_master_i (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_d(scl_d),
    .sda_d(sda_d), .stuck(m_stuck));

  // Clock and time-zero inputs
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, slave_mode, ten_bit, gce, address_hold_enable} = 5'b1_1000;
    {mask_write, ack_val, clk_rel, ua_clr} = 4'b0000;
    own = 10'h055;
    mask_wdata = 8'h00;
    {err_count, n_checks, ev_cnt} = '0;
  end
  // Count one-cycle receive events
  always @(posedge clk) if (rx_ev === 1'b1) ev_cnt++;

  // Compare tasks
  task automatic chk_bit(input logic a, input logic e);
    n_checks++;
    if (a !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic chk_byte(input logic [7:0] a, input logic [7:0] e);
    n_checks++;
    if (a !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Mask write with readback
  task automatic set_mask(input logic [7:0] m);
    @(negedge clk);
    mask_wdata = m;
    mask_write = 1'b1;
    @(negedge clk);
    mask_write = 1'b0;
    chk_byte(mask_reg, m);
  endtask
  // One byte on the bus; event count 8'hFF skips that check
  task automatic xbyte(input logic [7:0] d, input logic ea, input logic [7:0] ee);
    int   e0;
    logic ack;
    e0 = ev_cnt;
    isam_master_i.send_byte(d, ack);
    chk_bit(ack, ea);
    if (ee !== 8'hFF) chk_byte(8'(ev_cnt - e0), ee);
    if (ea) chk_byte(rx_buf, d);
  endtask
  // Pulse the update-address clear
  task automatic clr_ua();
    ua_clr = 1'b1;
    @(negedge clk);
    ua_clr = 1'b0;
  endtask

  // Watchdog
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    int k;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_byte(mask_reg, isam_pkg::MASK_RESET);
    chk_bit(status.gen_call, 1'b0);
    isam_master_i.start_c();
    xbyte(8'h00, 1'b0, 8'h00);
    isam_master_i.stop_c();
    gce = 1'b1;
    isam_master_i.start_c();
    xbyte(8'h00, 1'b1, 8'h01);
    chk_bit(status.gen_call, 1'b1);
    xbyte(8'hA5, 1'b1, 8'h01);
    isam_master_i.stop_c();
    isam_master_i.start_c();
    xbyte(8'hAE, 1'b0, 8'h00);
    isam_master_i.stop_c();
    set_mask(8'hFB);
    isam_master_i.start_c();
    xbyte(8'hAE, 1'b1, 8'h01);
    chk_bit(status.addr_match, 1'b1);
    isam_master_i.stop_c();
    set_mask(8'h7B);
    isam_master_i.start_c();
    xbyte(8'h2E, 1'b1, 8'h01);
    isam_master_i.stop_c();
    slave_mode = 1'b0;
    isam_master_i.start_c();
    xbyte(8'hAA, 1'b0, 8'h00);
    isam_master_i.stop_c();
    {slave_mode, ten_bit, own} = {2'b11, 10'h2A5};
    set_mask(8'hFF);
    isam_master_i.start_c();
    xbyte(8'hF4, 1'b1, 8'hFF);
    chk_bit(status.update_address_flag, 1'b1);
    xbyte(8'hA5, 1'b1, 8'hFF);
    isam_master_i.stop_c();
    set_mask(8'h00);
    isam_master_i.start_c();
    xbyte(8'hF6, 1'b0, 8'h00);
    isam_master_i.start_c();
    xbyte(8'hF4, 1'b1, 8'hFF);
    xbyte(8'h3C, 1'b1, 8'hFF);
    isam_master_i.stop_c();
    clr_ua();
    chk_bit(status.update_address_flag, 1'b0);
    set_mask(8'hFF);
    isam_master_i.start_c();
    xbyte(8'h00, 1'b1, 8'h01);
    chk_bit(status.update_address_flag, 1'b0);
    xbyte(8'h3C, 1'b1, 8'h01);
    isam_master_i.stop_c();
    // Reset again in mid-run: mask and flags return to their reset values
    set_mask(8'h0F);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_byte(mask_reg, isam_pkg::MASK_RESET);
    chk_bit(status.gen_call, 1'b0);
    // Stretched general call, released with acknowledge then with refusal
    {ten_bit, address_hold_enable} = 2'b01;
    for (int v = 0; v < 2; v++) begin
      isam_master_i.start_c();
      fork
        xbyte(8'h00, (v == 0), 8'h01);
        begin
          k = 0;
          while (status.hold !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
          end
          chk_bit(scl_oe_n, 1'b0);
          repeat (20) @(negedge clk);
          chk_bit(scl_w, 1'b0);
          ack_val = (v != 0);
          clk_rel = 1'b1;
          @(negedge clk);
          clk_rel = 1'b0;
        end
      join
      isam_master_i.stop_c();
    end
    chk_bit(m_stuck, 1'b0);
    print_verdict();
  end
endmodule
